// [pmc_core_model.sv]
// far-side model: cpu core and peripheral clock consumers
module pmc_core_model (
	// clock and gates seen from the far side
	input  logic                mclk_i,
	input  pmc_pkg::pmc_gates_t gates_i,
	input  logic                pb_pulse_i,
	// event commands from the bench
	input  logic [7:0]          evt_i,
	output logic [7:0]          wake_o,
	// activity counters
	output int                  n_cpu_o,
	output int                  n_pb_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		wake_o = 8'h00;
		n_cpu_o = 0;
		n_pb_o = 0;
	end
	// events leave registered, one cycle late and as wide as given; count clocked cycles seen
	always @(posedge mclk_i) begin
		wake_o <= evt_i;
		n_cpu_o <= n_cpu_o + int'(gates_i.cpu_clk);
		n_pb_o <= n_pb_o + int'(pb_pulse_i);
	end
endmodule : pmc_core_model

// [pmc_pbdiv.sv]
// peripheral bus clock divider, one-cycle enable pulses
`include "pmc_regs.svh"
module pmc_pbdiv (
	// clock and reset
	input  wire logic                   mclk_i,
	input  wire logic                   rst_n_i,
	// control
	input  wire logic                   run_i,
	input  wire logic [`PMC_DIV_W-1:0]  div_sel_i,
	// enable out
	output logic                        pulse_o
);
	logic [7:0] cnt;        // cycle counter
	wire  [7:0] limit;      // divide by 2^sel
	wire        wrap;       // end of period
	assign limit = 8'((8'h01 << div_sel_i) - 8'h01);
	assign wrap  = (cnt >= limit);
	// ***************************************************************
	// counter
	// ***************************************************************
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt     <= 8'h00;
			pulse_o <= 1'b0;
		end else if (!run_i) begin
			pulse_o <= 1'b0;   // stalled with the system clock
		end else begin
			cnt     <= wrap ? 8'h00 : 8'(cnt + 8'h01);
			pulse_o <= wrap;
		end
	end
endmodule : pmc_pbdiv

// [pmc_pkg.sv]
// types shared by the power mode controller
package pmc_pkg;
	// ***************************************************************
	// mode states
	// ***************************************************************
	typedef enum logic [1:0] {
		PMC_RUN,
		PMC_IDLE,
		PMC_SLEEP,
		PMC_WAKE
	} pmc_state_t;
	// clock gate bundle: peripheral gates, cpu clock and source run
	typedef struct packed {
		logic [7:0] clk_en;   // peripheral clock gates
		logic       cpu_clk;  // cpu clock enable
		logic       src_run;  // system clock source running
	} pmc_gates_t;
endpackage : pmc_pkg

// [pmc_regs.svh]
// constants for the power mode controller
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH
// ***************************************************************
// clock source codes
// ***************************************************************
`define PMC_SRC_PRIMARY      3'h0
`define PMC_SRC_FAST_INT     3'h1
`define PMC_SRC_FAST_INT_DIV 3'h2
`define PMC_SRC_SECONDARY    3'h3
`define PMC_SRC_LOW_POWER    3'h4
// ***************************************************************
// wake start-up delays in ns, converted to 100 MHz cycles
// ***************************************************************
`define PMC_CLK_PERIOD_NS    10
`define PMC_WAKE_PRI_NS      20000
`define PMC_WAKE_FAST_NS     2000
`define PMC_WAKE_SEC_NS      40000
`define PMC_WAKE_LP_NS       1000
`define PMC_WAKE_PRI_CYC  ((`PMC_WAKE_PRI_NS+`PMC_CLK_PERIOD_NS-1)/`PMC_CLK_PERIOD_NS)
`define PMC_WAKE_FAST_CYC ((`PMC_WAKE_FAST_NS+`PMC_CLK_PERIOD_NS-1)/`PMC_CLK_PERIOD_NS)
`define PMC_WAKE_SEC_CYC  ((`PMC_WAKE_SEC_NS+`PMC_CLK_PERIOD_NS-1)/`PMC_CLK_PERIOD_NS)
`define PMC_WAKE_LP_CYC   ((`PMC_WAKE_LP_NS+`PMC_CLK_PERIOD_NS-1)/`PMC_CLK_PERIOD_NS)
// ***************************************************************
// widths and peripheral count
// ***************************************************************
`define PMC_NUM_PERIPH       8
`define PMC_DIV_W            3
`define PMC_WAKE_W           13
`define PMC_WATCHDOG_W       16
`endif

// [pmc_top.sv]
// power mode controller: run, idle and sleep sequencing
`include "pmc_regs.svh"
module pmc_top (
	// clock and reset
	input  wire logic                      mclk_i,
	input  wire logic                      rst_n_i,
	// software control
	input  wire logic                      wait_req_i,
	input  wire logic                      sleep_sel_i,
	input  wire logic [2:0]                clk_src_i,
	input  wire logic [`PMC_DIV_W-1:0]     pb_div_i,
	input  wire logic [`PMC_NUM_PERIPH-1:0] periph_en_i,
	input  wire logic [`PMC_NUM_PERIPH-1:0] sleep_capable_i,
	input  wire logic [`PMC_NUM_PERIPH-1:0] periph_wake_i,
	// safety functions
	input  wire logic                      watchdog_en_i,
	input  wire logic                      watchdog_clr_i,
	input  wire logic                      brownout_en_i,
	input  wire logic                      brownout_det_i,
	input  wire logic                      clk_fail_i,
	// port pins
	input  wire logic [7:0]                port_out_i,
	input  wire logic [7:0]                port_oe_i,
	output logic [7:0]                     port_out_o,
	output logic [7:0]                     port_oe_o,
	// clock gates and status
	output logic                           cpu_clk_en_o,
	output logic                           src_run_o,
	output logic [2:0]                     sys_src_o,
	output logic                           peripheral_bus_clock_o,
	output logic [`PMC_NUM_PERIPH-1:0]     periph_clk_en_o,
	output logic [1:0]                     mode_o,
	output logic                           clock_failure_monitor_o,
	output logic                           brownout_reset_o,
	output logic [`PMC_WATCHDOG_W-1:0]     watchdog_counter_o
);
	// ***************************************************************
	// state and decode
	// ***************************************************************
	pmc_pkg::pmc_state_t state;          // current mode
	pmc_pkg::pmc_state_t next_state;     // next mode
	pmc_pkg::pmc_gates_t next_gates;     // next gate values
	logic [`PMC_WAKE_W-1:0] wake_cnt;    // start-up delay counter
	logic [`PMC_WAKE_W-1:0] wake_len;    // delay for selected source
	wire  wake_evt;                      // enabled event seen
	wire  sleep_evt;                     // event from sleep survivor
	wire  pb_pulse;                      // divider enable
	wire  src_live;                      // source running now
	wire  mon_live;                      // failure monitor allowed
	assign wake_evt  = |(periph_wake_i & periph_en_i);
	assign sleep_evt = |(periph_wake_i & periph_en_i & sleep_capable_i);
	assign src_live  = (state != pmc_pkg::PMC_SLEEP);
	// monitor goes quiet on the very edge that enters sleep
	assign mon_live  = (next_state != pmc_pkg::PMC_SLEEP);
	// delay length from source
	always_comb begin
		case (sys_src_o)
			`PMC_SRC_PRIMARY:   wake_len = `PMC_WAKE_W'(`PMC_WAKE_PRI_CYC);
			`PMC_SRC_SECONDARY: wake_len = `PMC_WAKE_W'(`PMC_WAKE_SEC_CYC);
			`PMC_SRC_LOW_POWER: wake_len = `PMC_WAKE_W'(`PMC_WAKE_LP_CYC);
			default:            wake_len = `PMC_WAKE_W'(`PMC_WAKE_FAST_CYC);
		endcase
	end
	// ***************************************************************
	// next mode
	// ***************************************************************
	always_comb begin
		next_state = state;
		case (state)
			pmc_pkg::PMC_RUN: begin
				if (wait_req_i) begin
					next_state = sleep_sel_i ? pmc_pkg::PMC_SLEEP
					                         : pmc_pkg::PMC_IDLE;
				end
			end
			pmc_pkg::PMC_IDLE: begin
				if (wake_evt) begin
					next_state = pmc_pkg::PMC_RUN;
				end
			end
			pmc_pkg::PMC_SLEEP: begin
				if (sleep_evt) begin
					next_state = pmc_pkg::PMC_WAKE;
				end
			end
			pmc_pkg::PMC_WAKE: begin
				if (wake_cnt == `PMC_WAKE_W'(1)) begin
					next_state = pmc_pkg::PMC_RUN;
				end
			end
			default: next_state = pmc_pkg::PMC_RUN;
		endcase
	end
	// ***************************************************************
	// gate values for the next mode
	// ***************************************************************
	always_comb begin
		next_gates.cpu_clk = (next_state == pmc_pkg::PMC_RUN);
		next_gates.src_run = (next_state != pmc_pkg::PMC_SLEEP);
		if (next_state == pmc_pkg::PMC_SLEEP) begin
			next_gates.clk_en = periph_en_i & sleep_capable_i;
		end else begin
			next_gates.clk_en = periph_en_i;
		end
	end
	// ***************************************************************
	// bus clock divider
	// ***************************************************************
	pmc_pbdiv u_pbdiv (
		.mclk_i    (mclk_i),
		.rst_n_i   (rst_n_i),
		.run_i     (src_live),
		.div_sel_i (pb_div_i),
		.pulse_o   (pb_pulse)
	);
	// ***************************************************************
	// mode register and wake counter
	// ***************************************************************
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state    <= pmc_pkg::PMC_RUN;
			wake_cnt <= `PMC_WAKE_W'(0);
		end else begin
			state <= next_state;
			if (state == pmc_pkg::PMC_SLEEP && sleep_evt) begin
				wake_cnt <= wake_len;
			end else if (wake_cnt != `PMC_WAKE_W'(0)) begin
				wake_cnt <= wake_cnt - `PMC_WAKE_W'(1);
			end
		end
	end
	// ***************************************************************
	// clock gates and source select
	// ***************************************************************
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cpu_clk_en_o    <= 1'b1;
			src_run_o       <= 1'b1;
			periph_clk_en_o <= '0;
			sys_src_o       <= `PMC_SRC_FAST_INT;
			mode_o          <= 2'h0;
		end else begin
			cpu_clk_en_o    <= next_gates.cpu_clk;
			src_run_o       <= next_gates.src_run;
			periph_clk_en_o <= next_gates.clk_en;
			mode_o          <= next_state;
			if (state == pmc_pkg::PMC_RUN) begin
				sys_src_o <= clk_src_i;
			end
		end
	end
	// ***************************************************************
	// bus clock enable, monitors and watchdog
	// ***************************************************************
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			peripheral_bus_clock_o  <= 1'b0;
			clock_failure_monitor_o <= 1'b0;
			brownout_reset_o        <= 1'b0;
			watchdog_counter_o      <= '0;
		end else begin
			peripheral_bus_clock_o  <= pb_pulse;
			clock_failure_monitor_o <= clk_fail_i && mon_live;
			brownout_reset_o        <= brownout_en_i && brownout_det_i;
			if (watchdog_clr_i) begin
				watchdog_counter_o <= '0;
			end else if (watchdog_en_i) begin
				watchdog_counter_o <=
					16'(watchdog_counter_o + 16'h0001);
			end
		end
	end
	// ***************************************************************
	// port pins held through sleep
	// ***************************************************************
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			port_out_o <= 8'h00;
			port_oe_o  <= 8'h00;
		end else if (state != pmc_pkg::PMC_SLEEP) begin
			port_out_o <= port_out_i;
			port_oe_o  <= port_oe_i;
		end
	end
endmodule : pmc_top

// [pmc_top_monitor.sv]
// concurrent checks on the power mode controller ports
module pmc_top_monitor (
	// clock and reset
	input  logic        mclk_i,
	input  logic        rst_n_i,
	// software requests and levels
	input  logic        wait_req_i,
	input  logic        sleep_sel_i,
	input  logic        watchdog_en_i,
	input  logic        watchdog_clr_i,
	input  logic        brownout_en_i,
	input  logic        brownout_det_i,
	input  logic [7:0]  periph_en_i,
	input  logic [7:0]  sleep_capable_i,
	input  logic [7:0]  periph_wake_i,
	// gates and status
	input  logic        cpu_clk_en_o,
	input  logic        src_run_o,
	input  logic        clock_failure_monitor_o,
	input  logic        brownout_reset_o,
	input  logic [1:0]  mode_o,
	input  logic [2:0]  sys_src_o,
	input  logic [7:0]  periph_clk_en_o,
	input  logic [7:0]  port_out_o,
	input  logic [7:0]  port_oe_o,
	input  logic [15:0] watchdog_counter_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	logic [12:0] wcnt; // cycles spent holding the cpu on wake
	logic [12:0] wexp; // start-up delay of the latched source
	assign wexp = (sys_src_o == 3'h0) ? 13'h07D0 : (sys_src_o == 3'h3) ?
		13'h0FA0 : (sys_src_o == 3'h4) ? 13'h0064 : 13'h00C8;
	// wake delay counter
	always_ff @(posedge mclk_i or negedge rst_n_i)
		if (!rst_n_i) wcnt <= '0;
		else wcnt <= (mode_o == 2'h3) ? wcnt + 13'h0001 : '0;
	a_cpu_halted: assert property (
		mode_o != 2'h0 |-> !cpu_clk_en_o) else $error("cpu clock on");
	a_idle_gates: assert property (
		mode_o == 2'h1 |-> src_run_o && periph_clk_en_o == $past(periph_en_i))
		else $error("idle gates wrong");
	a_sleep_gates: assert property (
		mode_o == 2'h2 |-> !src_run_o &&
		periph_clk_en_o == ($past(periph_en_i) & $past(sleep_capable_i)))
		else $error("sleep gates wrong");
	a_sleep_wake: assert property (
		mode_o == 2'h2 && |(periph_wake_i & sleep_capable_i & periph_en_i)
		|=> mode_o == 2'h3) else $error("no wake from sleep");
	a_wake_delay: assert property (
		$fell(mode_o == 2'h3) |-> mode_o == 2'h0 &&
		$past(wcnt) + 13'h0001 inside {[wexp - 13'h0001:wexp + 13'h0001]})
		else $error("wake delay wrong");
	a_monitor_off: assert property (
		mode_o == 2'h2 |-> !clock_failure_monitor_o)
		else $error("clock monitor active in sleep");
	a_brownout_live: assert property (
		mode_o == 2'h2 && brownout_en_i && brownout_det_i |-> ##[0:2]
		brownout_reset_o) else $error("brownout lost in sleep");
	a_watchdog_counts: assert property (
		watchdog_en_i && !watchdog_clr_i && $past(watchdog_en_i) &&
		!$past(watchdog_clr_i) |=>
		watchdog_counter_o == $past(watchdog_counter_o) + 16'h0001)
		else $error("watchdog not counting");
	a_pins_frozen: assert property (
		mode_o == 2'h2 && $past(mode_o) == 2'h2 |->
		$stable(port_out_o) && $stable(port_oe_o)) else $error("pins moved");
	a_no_self_entry: assert property (
		mode_o == 2'h0 && !wait_req_i |=> mode_o == 2'h0)
		else $error("left run without request");
	a_wait_select: assert property (
		mode_o == 2'h0 && wait_req_i |=>
		mode_o == ($past(sleep_sel_i) ? 2'h2 : 2'h1)) else $error("bad mode");
	a_idle_wake: assert property (
		mode_o == 2'h1 && |(periph_wake_i & periph_en_i) |=>
		mode_o == 2'h0 && cpu_clk_en_o) else $error("slow idle wake");
endmodule : pmc_top_monitor
bind pmc_top pmc_top_monitor u_mon (.*);

// [tb.sv]
// self-checking bench for the power mode controller
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	// design inputs
	logic mclk_i = 1'b0, rst_n_i = 1'b0, wait_req_i = 1'b0, sleep_sel_i = 1'b0;
	logic watchdog_en_i = 1'b1, watchdog_clr_i = 1'b0, brownout_en_i = 1'b1;
	logic brownout_det_i = 1'b0, clk_fail_i = 1'b0;
	logic [2:0] clk_src_i = 3'h1, pb_div_i = 3'h0;
	logic [7:0] periph_en_i = 8'h0F, sleep_capable_i = 8'h15, evt = 8'h00;
	logic [7:0] port_out_i = 8'hA5, port_oe_i = 8'h3C, periph_wake_i;
	// design outputs
	logic cpu_clk_en_o, src_run_o, peripheral_bus_clock_o;
	logic clock_failure_monitor_o, brownout_reset_o;
	logic [1:0] mode_o;
	logic [2:0] sys_src_o;
	logic [7:0] periph_clk_en_o, port_out_o, port_oe_o, po, poe;
	logic [15:0] watchdog_counter_o, w0;
	pmc_pkg::pmc_gates_t gates;
	int mismatches = 0, n_checks = 0, n_cpu, n_pb, n, c;
	int srcs[5] = '{0, 1, 2, 3, 4};
	int dly[5] = '{2000, 200, 200, 4000, 100};
	assign gates = {periph_clk_en_o, cpu_clk_en_o, src_run_o};
	always #5 mclk_i = ~mclk_i;
	pmc_top u_dut (.mclk_i, .rst_n_i, .wait_req_i, .sleep_sel_i, .clk_src_i,
		.pb_div_i, .periph_en_i, .sleep_capable_i, .periph_wake_i,
		.watchdog_en_i, .watchdog_clr_i, .brownout_en_i, .brownout_det_i,
		.clk_fail_i, .port_out_i,
		.port_oe_i, .port_out_o, .port_oe_o, .cpu_clk_en_o, .src_run_o,
		.sys_src_o, .peripheral_bus_clock_o, .periph_clk_en_o, .mode_o,
		.clock_failure_monitor_o, .brownout_reset_o, .watchdog_counter_o);
	pmc_core_model u_core (.mclk_i, .gates_i(gates), .evt_i(evt),
		.pb_pulse_i(peripheral_bus_clock_o), .wake_o(periph_wake_i),
		.n_cpu_o(n_cpu), .n_pb_o(n_pb));
	task step(input int k);
		repeat (k) @(posedge mclk_i);
		#1;
	endtask : step
	task chk(input logic [15:0] got, input logic [15:0] exp, input string s);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: %s", $time, s);
		end
	endtask : chk
	// one wait request, held for one edge
	task req(input logic sel);
		wait_req_i = 1'b1;
		sleep_sel_i = sel;
		step(1);
		wait_req_i = 1'b0;
		step(1);
	endtask : req
	// event from a sleep-capable module, then wait for run
	task wake_up;
		evt = 8'h01;
		step(1);
		evt = 8'h00;
		n = 1;
		while (mode_o !== 2'h0 && n < 5000) begin
			step(1);
			n++;
		end
	endtask : wake_up
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	initial begin
		#200000;
		mismatches++;
		wrap_up();
	end
	initial begin
		step(3);
		chk({cpu_clk_en_o, src_run_o, sys_src_o, mode_o}, 16'h0064, "reset");
		rst_n_i = 1'b1;
		for (int d = 0; d < 4; d++) begin
			pb_div_i = d[2:0];
			step(8);
			c = n_pb;
			step(64);
			chk(16'(n_pb - c), 16'(64 >> d), "bus clock rate");
		end
		$display("test bus clock done");
		req(1'b0);
		chk({cpu_clk_en_o, src_run_o, mode_o}, 16'h0005, "idle");
		chk(periph_clk_en_o, 8'h0F, "idle periph");
		c = n_cpu;
		req(1'b1);
		chk(mode_o, 2'h1, "wait in idle");
		chk(16'(n_cpu - c), 16'h0000, "cpu ran in idle");
		evt = 8'h02;
		step(1);
		evt = 8'h00;
		step(2);
		chk({cpu_clk_en_o, mode_o}, 16'h0004, "idle wake");
		$display("test idle done");
		for (int i = 0; i < 5; i++) begin
			clk_src_i = srcs[i][2:0];
			step(3);
			chk(sys_src_o, clk_src_i, "source");
			w0 = watchdog_counter_o;
			clk_fail_i = 1'b1;
			req(1'b1);
			chk({cpu_clk_en_o, src_run_o, mode_o}, 16'h0002, "sleep");
			chk(periph_clk_en_o, 8'h05, "sleep periph");
			chk(watchdog_counter_o > w0, 16'h0001, "watchdog");
			po = port_out_o;
			poe = port_oe_o;
			port_out_i = ~port_out_i;
			port_oe_i = ~port_oe_i;
			evt = 8'h12;
			step(1);
			evt = 8'h00;
			step(3);
			chk(port_out_o, po, "pins");
			chk(port_oe_o, poe, "pin enables");
			chk(clock_failure_monitor_o, 1'b0, "clock monitor");
			chk(mode_o, 2'h2, "stray wake");
			wake_up();
			chk(clock_failure_monitor_o, 1'b1, "clock monitor in run");
			chk({port_oe_o, port_out_o}, {port_oe_i, port_out_i}, "pins back");
			clk_fail_i = 1'b0;
			chk(n >= dly[i] && n <= dly[i] + 3, 16'h0001, "delay");
			chk(cpu_clk_en_o, 1'b1, "cpu back");
			$display("test sleep source %0d done", srcs[i]);
		end
		req(1'b1);
		brownout_det_i = 1'b1;
		step(2);
		chk(brownout_reset_o, 1'b1, "brownout in sleep");
		brownout_det_i = 1'b0;
		wake_up();
		$display("test brownout done");
		wrap_up();
	end
endmodule : tb
